// ==== rtl/acr_regs.svh ====
// Constants for the converter control fields and continuous read link.
// Assumes inclusion by bare name from the core and its package users.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ==========================================================
// Control register layout and reset
`define ACR_CTRL_RESET 16'h4000
`define ACR_CTRL_WMASK 16'h7FFF
`define ACR_REF_VAL_BIT 13
`define ACR_REL_DEL_BIT 12
`define ACR_CONT_BIT 11
`define ACR_CS_USE_BIT 9
`define ACR_REF_EN_BIT 8

// ==========================================================
// Frame layout and link commands
`define ACR_DATA_BITS 6'h18
`define ACR_FULL_BITS 6'h20
`define ACR_EXIT_CMD 8'h42
`define ACR_RESET_ONES 7'h40
`define ACR_ABORT_LEAD 4

// ==========================================================
// Timing, in ns and in core clock cycles (longest time, rounded down)
`define ACR_CLK_NS 5
`define ACR_REL_SHORT_NS 10
`define ACR_REL_LONG_NS 100
`define ACR_REL_SHORT_CYC ((`ACR_REL_SHORT_NS) / (`ACR_CLK_NS))
`define ACR_REL_LONG_CYC ((`ACR_REL_LONG_NS) / (`ACR_CLK_NS))

`endif

// ==== rtl/acr_pkg.sv ====
// Types shared by the continuous read core.
// Assumes nothing beyond a SystemVerilog compiler.
package acr_pkg;
   // Result frame state in the core domain
   typedef enum logic [1:0] {FR_IDLE, FR_READY, FR_RELEASE} acr_frame_e;
   typedef logic [23:0] acr_word_t;
endpackage

// ==== rtl/acr_fifo.sv ====
// Result FIFO between the modulator output and the serial result holder.
// Assumes one clock; all flags come from flip-flops.
`timescale 1ns/1ps
module acr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   // ==========================================================
   // Handshakes
   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;
   assign out_data = mem[rd_ptr];

   // Occupancy after this cycle
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + (AW+1)'(1);
      end else if (pop && !push) begin
         next_count = count - (AW+1)'(1);
      end
   end

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers, count and registered flags
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= next_count;
         in_ready <= (next_count != (AW+1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end
endmodule

// ==== rtl/acr_core.sv ====
// Control fields and continuous result read over the serial link.
// Assumes core_clk is the master clock; sclk comes from the host, idles
// high, and runs inside frames framed by rdy_n and to send commands.
//
// Notes on behaviour
// [R1] Value field picks 2.5 V or 1.25 V
// [R2] Value field acts only with reference enable
// [R3] Without chip select, release output after delay
// [R4] Continuous mode shifts data without a command
// [R5] Host clocks only after data ready falls
// [R6] Clocks ignored until ready; each result once
// [R7] Read abandoned four cycles before next result
// [R8] Checksum exposes an abandoned read to host
// [R9] Host exits with 64 ones or 0x42
// [R10] Exit command accepted without any checksum
// [R11] FIFO enable disables continuous read
// [R12] Continuous field enables the mode, resets clear
`timescale 1ns/1ps
`include "acr_regs.svh"
module acr_core
   import acr_pkg::*;
#(
   parameter int CONV_CYCLES = 100,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic cs_n,
   input wire logic [23:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic ctrl_wr,
   input wire logic [15:0] ctrl_wdata,
   input wire logic fifo_enable,
   input wire logic crc_enable,
   output logic [15:0] ctrl_reg,
   output logic ref_on,
   output logic ref_low_sel,
   output logic rdy_n,
   output logic dout,
   output logic dout_oe
);
   // Gray code to binary, used for the edge count crossing
   function automatic logic [5:0] gray2bin(input logic [5:0] g);
      logic [5:0] b;
      b[5] = g[5];
      for (int i = 4; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // ==========================================================
   // Core domain declarations
   acr_frame_e state;
   logic [15:0] conv_cnt;
   acr_word_t hold_word;
   logic [7:0] hold_sum;
   logic frame_tag;
   logic frame_open;
   logic [5:0] frame_len;
   logic [5:0] edge_base;
   logic [5:0] eg_s1, eg_s2;
   logic rt_s1, rt_s2, rt_s3;
   logic xt_s1, xt_s2, xt_s3;
   logic cs_s1, cs_s2;
   logic [4:0] rel_cnt;
   logic fifo_valid;
   acr_word_t fifo_data;
   logic cont_active, conv_done, lead, load, go_release, done;
   logic soft_rst, exit_evt;
   logic [5:0] bits_taken;
   logic sr_s1, sr_s2;
   logic tag_seen;
   logic [5:0] idx;
   logic [5:0] edge_cnt;
   logic [5:0] edge_gray;
   logic [6:0] ones_cnt;
   logic [6:0] cmd_sh;
   logic [2:0] cmd_cnt;
   logic rst_tog, exit_tog;
   logic [31:0] out_word;
   logic [5:0] next_edge;

   // ==========================================================
   // Control register and reference outputs
   assign soft_rst = rt_s2 ^ rt_s3;
   assign exit_evt = xt_s2 ^ xt_s3;
   assign cont_active = ctrl_reg[`ACR_CONT_BIT] & ~fifo_enable; // R11 R12

   // Field writes; the exit command clears the continuous field
   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_rst) begin
         ctrl_reg <= `ACR_CTRL_RESET; // R12
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= ctrl_wdata & `ACR_CTRL_WMASK;
         end
         if (exit_evt) begin
            ctrl_reg[`ACR_CONT_BIT] <= 1'b0; // R10
         end
      end
   end

   // Reference enable and level
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ref_on <= 1'b0;
         ref_low_sel <= 1'b0;
      end else begin
         ref_on <= ctrl_reg[`ACR_REF_EN_BIT]; // R2
         ref_low_sel <= ctrl_reg[`ACR_REF_EN_BIT] & ctrl_reg[`ACR_REF_VAL_BIT]; // R1 R2
      end
   end

   // ==========================================================
   // Result FIFO and conversion timing
   acr_fifo #(
      .WIDTH(24),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(core_clk),
      .rst_n(rst_n),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(load),
      .out_data(fifo_data)
   );

   assign conv_done = (conv_cnt == 16'(CONV_CYCLES - 1));
   assign lead = (conv_cnt == 16'(CONV_CYCLES - 1 - `ACR_ABORT_LEAD));
   assign load = conv_done && fifo_valid && (state == FR_IDLE) && cont_active; // R11
   assign bits_taken = gray2bin(eg_s2) - edge_base;
   assign done = (bits_taken >= frame_len);
   assign go_release = (state == FR_READY) && done && cont_active;

   // Conversion period counter
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         conv_cnt <= '0;
      end else begin
         conv_cnt <= conv_done ? '0 : conv_cnt + 16'h0001;
      end
   end

   // ==========================================================
   // Crossings into the core domain
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         eg_s1 <= '0;
         eg_s2 <= '0;
         rt_s1 <= 1'b0;
         rt_s2 <= 1'b0;
         rt_s3 <= 1'b0;
         xt_s1 <= 1'b0;
         xt_s2 <= 1'b0;
         xt_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
      end else begin
         eg_s1 <= edge_gray;
         eg_s2 <= eg_s1;
         rt_s1 <= rst_tog;
         rt_s2 <= rt_s1;
         rt_s3 <= rt_s2;
         xt_s1 <= exit_tog;
         xt_s2 <= xt_s1;
         xt_s3 <= xt_s2;
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
      end
   end

   // ==========================================================
   // Frame state, data ready and output enable
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= FR_IDLE;
         rdy_n <= 1'b1;
         frame_open <= 1'b0;
         frame_tag <= 1'b0;
         frame_len <= `ACR_DATA_BITS;
         edge_base <= '0;
         hold_word <= '0;
         hold_sum <= '0;
         rel_cnt <= '0;
      end else begin
         case (state)
            FR_IDLE: begin
               if (load) begin
                  hold_word <= fifo_data;
                  hold_sum <= fifo_data[23:16] ^ fifo_data[15:8] ^ fifo_data[7:0]; // R8
                  frame_len <= crc_enable ? `ACR_FULL_BITS : `ACR_DATA_BITS; // R8
                  frame_tag <= ~frame_tag;
                  edge_base <= gray2bin(eg_s2);
                  rdy_n <= 1'b0;
                  frame_open <= cont_active; // R4 R11
                  state <= FR_READY;
               end
            end
            FR_READY: begin
               if (go_release) begin
                  rdy_n <= 1'b1; // R6
                  frame_open <= 1'b0;
                  rel_cnt <= ctrl_reg[`ACR_REL_DEL_BIT] ? 5'(`ACR_REL_LONG_CYC - 1)
                                                        : 5'(`ACR_REL_SHORT_CYC - 1); // R3
                  state <= FR_RELEASE;
               end else if (lead) begin
                  rdy_n <= 1'b1; // R7
                  frame_open <= 1'b0;
                  state <= FR_IDLE;
               end else if (!cont_active) begin
                  frame_open <= 1'b0; // R11
               end
            end
            FR_RELEASE: begin
               if (rel_cnt == '0) begin
                  state <= FR_IDLE;
               end else begin
                  rel_cnt <= rel_cnt - 5'h01;
               end
            end
            default: begin
               state <= FR_IDLE;
            end
         endcase
      end
   end

   // Output enable: chip select or timed release
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dout_oe <= 1'b0;
      end else if (ctrl_reg[`ACR_CS_USE_BIT]) begin
         dout_oe <= ~cs_s2 & cont_active;
      end else if (load && cont_active) begin
         dout_oe <= 1'b1; // R4
      end else if ((state == FR_RELEASE && rel_cnt == '0) || (state == FR_READY && lead && !done)) begin
         dout_oe <= 1'b0; // R3 R7
      end
   end

   // ==========================================================
   // Link domain on sclk

   assign out_word = {hold_word, hold_sum};
   assign next_edge = edge_cnt + 6'h01;

   // Reset brought into the link domain
   always_ff @(posedge sclk) begin
      sr_s1 <= rst_n;
      sr_s2 <= sr_s1;
   end

   // Bit counting, only while a frame is open
   always_ff @(posedge sclk) begin
      if (!sr_s2) begin
         tag_seen <= 1'b0;
         idx <= '0;
         edge_cnt <= '0;
         edge_gray <= '0;
      end else if (frame_open) begin // R6
         if (frame_tag != tag_seen) begin
            tag_seen <= frame_tag;
            idx <= 6'h01;
            edge_cnt <= next_edge;
            edge_gray <= next_edge ^ (next_edge >> 1);
         end else if (idx < frame_len) begin
            idx <= idx + 6'h01;
            edge_cnt <= next_edge;
            edge_gray <= next_edge ^ (next_edge >> 1);
         end
      end
   end

   // Data bit presented on the falling edge, straight from the holder
   always_ff @(negedge sclk) begin
      if (!sr_s2) begin
         dout <= 1'b0;
      end else if (frame_tag != tag_seen) begin
         dout <= out_word[31]; // R4
      end else if (idx < `ACR_FULL_BITS) begin
         dout <= out_word[5'(6'h1F - idx)];
      end
   end

   // Exit decoding: 64 ones or the exit command byte, no checksum
   always_ff @(posedge sclk) begin
      if (!sr_s2) begin
         ones_cnt <= '0;
         cmd_sh <= '0;
         cmd_cnt <= '0;
         rst_tog <= 1'b0;
         exit_tog <= 1'b0;
      end else begin
         cmd_sh <= {cmd_sh[5:0], din};
         cmd_cnt <= cmd_cnt + 3'h1;
         if (!din) begin
            ones_cnt <= '0;
         end else if (ones_cnt == `ACR_RESET_ONES - 7'h01) begin
            ones_cnt <= `ACR_RESET_ONES;
            rst_tog <= ~rst_tog; // R9
            cmd_cnt <= '0;
         end else if (ones_cnt != `ACR_RESET_ONES) begin
            ones_cnt <= ones_cnt + 7'h01;
         end
         if (cmd_cnt == 3'h7 && {cmd_sh, din} == `ACR_EXIT_CMD) begin
            exit_tog <= ~exit_tog; // R9 R10
         end
      end
   end

   // ==========================================================
   // Checks
   chk_ref_level: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
      ctrl_reg[`ACR_REF_EN_BIT] |=> ref_low_sel == $past(ctrl_reg[`ACR_REF_VAL_BIT]))
      else $error("reference level does not follow value field");
   chk_ref_needs_en: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
      !ctrl_reg[`ACR_REF_EN_BIT] |=> !ref_on && !ref_low_sel)
      else $error("reference on without enable");
   chk_release_short: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
      go_release && !ctrl_reg[`ACR_REL_DEL_BIT] && !ctrl_reg[`ACR_CS_USE_BIT]
      |=> dout_oe ##1 dout_oe ##1 !dout_oe)
      else $error("short release delay wrong");
   chk_cont_start: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
      load && cont_active && !ctrl_reg[`ACR_CS_USE_BIT] |=> !rdy_n && dout_oe && frame_open)
      else $error("continuous frame did not open");
   chk_read_once: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
      go_release |=> (rdy_n && !frame_open) [*2])
      else $error("frame stayed open after full read");
   chk_abort_read: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
      state == FR_READY && lead && !done |=> rdy_n && state == FR_IDLE)
      else $error("read not abandoned before next result");
   chk_sum_frame: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
      load && crc_enable |=> frame_len == `ACR_FULL_BITS)
      else $error("checksum bits missing from frame");
   chk_exit_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
      exit_evt |=> !ctrl_reg[`ACR_CONT_BIT] && !cont_active)
      else $error("exit command did not leave continuous mode");
   chk_fifo_blocks: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
      fifo_enable && state == FR_IDLE |=> !frame_open)
      else $error("frame opened with fifo enabled");
   chk_cont_field: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
      ctrl_wr && !exit_evt && !soft_rst |=> ctrl_reg[`ACR_CONT_BIT] == $past(ctrl_wdata[`ACR_CONT_BIT]))
      else $error("continuous field not written");
endmodule

// ==== testbench/acr_host_model.sv ====
// Host controller model for the serial result link.
// Assumes sclk idles high and only runs inside frames or commands.
`timescale 1ns/1ps
module acr_host_model (
   output logic sclk,
   output logic din,
   output logic cs_n,
   input wire logic rdy_n,
   input wire logic dout
);
   // ==========================================
   // Idle levels
   initial begin
      sclk = 1'b1;
      din = 1'b0;
      cs_n = 1'b0;
   end

   // One clock pulse, data changed on the fall
   task automatic pulse(input logic bit_in, input realtime half);
      din = bit_in;
      sclk = 1'b0;
      #(half);
      sclk = 1'b1;
      #(half);
   endtask

   // Result frame, no command first, stops when ready rises
   task automatic read_frame(input int nbits, input realtime half,
      output logic [31:0] data, output int got);
      data = 32'h0;
      got = 0;
      #20;
      for (int i = 0; i < nbits; i++) begin
         if (rdy_n !== 1'b0) break;
         din = 1'b0;
         sclk = 1'b0;
         #(half);
         sclk = 1'b1;
         data = {data[30:0], dout};
         got++;
         #(half);
      end
   endtask

   // Command byte, most significant bit first
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) pulse(b[i], 7.5);
   endtask

   // Software reset run of ones
   task automatic send_ones();
      repeat (64) pulse(1'b1, 7.5);
   endtask
endmodule

// ==== testbench/acr_core_tb.sv ====
// Self-checking bench for the continuous result read core.
// Assumes the host model drives the link; core clock at 200 MHz.
`timescale 1ns/1ps
`include "acr_regs.svh"
module acr_core_tb
   import acr_pkg::*;
;
   localparam int CONV = 120;
   logic core_clk, rst_n, sclk, din, cs_n, sample_valid, sample_ready, ctrl_wr;
   logic fifo_enable, crc_enable, ref_on, ref_low_sel, rdy_n, dout, dout_oe;
   acr_word_t sample_data;
   logic [15:0] ctrl_wdata, ctrl_reg;
   logic [31:0] rdata;
   int got, fail_count, checks_done, cycles, low;
   acr_word_t w;

   // ==========================================
   // Design and host
   acr_core #(.CONV_CYCLES(CONV), .FIFO_DEPTH(16)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .sclk(sclk), .din(din), .cs_n(cs_n), .sample_data(sample_data),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .fifo_enable(fifo_enable), .crc_enable(crc_enable),
      .ctrl_reg(ctrl_reg), .ref_on(ref_on), .ref_low_sel(ref_low_sel), .rdy_n(rdy_n),
      .dout(dout), .dout_oe(dout_oe));
   acr_host_model host_u (.sclk(sclk), .din(din), .cs_n(cs_n), .rdy_n(rdy_n), .dout(dout));

   // Clock and watchdog
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         summarize();
      end
   end

   // ==========================================
   // Helpers
   function automatic acr_word_t wexp(input int i);
      return acr_word_t'(24'h5A3C00 + 24'h010101 * i);
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask

   task automatic wr(input logic [15:0] v);
      @(negedge core_clk);
      ctrl_wr = 1'b1;
      ctrl_wdata = v;
      @(negedge core_clk);
      ctrl_wr = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask

   task automatic push(input acr_word_t d);
      @(negedge core_clk);
      sample_valid = 1'b1;
      sample_data = d;
      @(posedge core_clk);
      while (sample_ready !== 1'b1) @(posedge core_clk);
      @(negedge core_clk);
      sample_valid = 1'b0;
   endtask

   task automatic rd(input int nb, input realtime h, input logic [31:0] exp, input bit whole);
      int n;
      n = 0;
      while (rdy_n !== 1'b0 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      chk("frame_open", 1, n < 400);
      host_u.read_frame(nb, h, rdata, got);
      // Let ready rise after a full frame before the next wait
      n = 0;
      while (rdy_n === 1'b0 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      if (whole) begin
         chk("frame_bits", nb, got);
      end
      chk("frame_data", exp >> (nb - got), rdata);
   endtask

   task automatic rel(input int exp);
      int n;
      n = 0;
      while (rdy_n !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      n = 0;
      while (dout_oe === 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      chk("release_delay", 1, (n + 2 >= exp) && (n <= exp + 2));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================
   // Test sequence
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      sample_data = '0;
      sample_valid = 1'b0;
      ctrl_wr = 1'b0;
      ctrl_wdata = 16'h0000;
      fifo_enable = 1'b0;
      crc_enable = 1'b0;
      fork
         repeat (4) host_u.pulse(1'b0, 7.5);
         repeat (20) @(negedge core_clk);
      join
      rst_n = 1'b1;
      @(negedge core_clk);
      chk("ctrl_reset", 16'h4000, ctrl_reg);
      chk("ref_low_reset", 0, ref_low_sel);
      // Two link edges bring the link logic out of reset
      repeat (2) host_u.pulse(1'b0, 7.5);
      wr(16'hFFFF);
      chk("ctrl_write", 16'h7FFF, ctrl_reg);
      chk("ref_on", 1, ref_on);
      chk("ref_low", 1, ref_low_sel);
      wr(16'h2000);
      chk("ref_off", 0, ref_on);
      chk("ref_low_off", 0, ref_low_sel);
      wr(16'h0100);
      chk("ref_high", 0, ref_low_sel);
      wr(16'h4000);
      // Fill the buffer until it refuses, nothing is read out
      @(negedge core_clk);
      sample_valid = 1'b1;
      for (int i = 0; i < 16; i++) begin
         sample_data = wexp(i);
         @(negedge core_clk);
      end
      sample_valid = 1'b0;
      repeat (20) @(negedge core_clk);
      chk("fifo_full", 0, sample_ready);
      // Drain in order through continuous read
      wr(16'h4800);
      for (int i = 0; i < 16; i++) begin
         rd(24, 7.5, {8'h00, wexp(i)}, 1'b1);
         if (i == 0) rel(`ACR_REL_SHORT_CYC);
      end
      chk("fifo_room", 1, sample_ready);
      // Checksum frame with long release
      crc_enable = 1'b1;
      wr(16'h5800);
      w = wexp(20);
      push(w);
      rd(32, 7.5, {w, w[23:16] ^ w[15:8] ^ w[7:0]}, 1'b1);
      rel(`ACR_REL_LONG_CYC);
      // FIFO enable holds the mode off
      crc_enable = 1'b0;
      wr(16'h4800);
      fifo_enable = 1'b1;
      push(wexp(21));
      low = 0;
      repeat (2 * CONV) begin
         @(negedge core_clk);
         if (rdy_n !== 1'b1) low++;
      end
      chk("fifo_mode_off", 0, low);
      fifo_enable = 1'b0;
      rd(24, 7.5, {8'h00, wexp(21)}, 1'b1);
      // Slow read is abandoned
      push(wexp(22));
      rd(24, 40.0, {8'h00, wexp(22)}, 1'b0);
      chk("read_abandoned", 1, got < 24);
      repeat (5) @(negedge core_clk);
      chk("abort_ready", 1, rdy_n);
      chk("abort_release", 0, dout_oe);
      // Leave the mode by ones run, then by command byte
      wr(16'h2B00);
      host_u.send_ones();
      repeat (10) @(negedge core_clk);
      chk("soft_reset", 16'h4000, ctrl_reg);
      wr(16'h2900);
      crc_enable = 1'b1;
      host_u.send_byte(`ACR_EXIT_CMD);
      repeat (10) @(negedge core_clk);
      chk("exit_cmd", 16'h2100, ctrl_reg);
      summarize();
   end
endmodule
